/* File: rtl/protector_defines.vh */
/*
 * constants for the protector fault/alert logic: bit positions of the
 * fault and alert status words, threshold codes and timing figures.
 * assumes inclusion by bare name from design files only.
 */
`ifndef PROTECTOR_DEFINES_VH
`define PROTECTOR_DEFINES_VH

// ----------------------------------------------------------------
// fault status bit positions
// ----------------------------------------------------------------
`define FLT_ECC_DOUBLE 0
`define FLT_FORCE 1
`define FLT_POR 2
`define FLT_CRC 3
`define FLT_CUV 4
`define FLT_COV 5
`define FLT_WIDTH 6

// ----------------------------------------------------------------
// alert status bit positions
// ----------------------------------------------------------------
`define ALR_ADDR 0
`define ALR_PARITY 1
`define ALR_ECC_CORRECTED_FLAG 2
`define ALR_FORCE 3
`define ALR_TSD 4
`define ALR_SLEEP 5
`define ALR_OT2 6
`define ALR_OT1 7
`define ALR_WIDTH 8

// ----------------------------------------------------------------
// thresholds, address range, timing
// ----------------------------------------------------------------
`define OT_CODE_DISABLED 4'h0
`define OT_CODE_MAX 4'hb
`define ADDR_MIN 6'h01
`define ADDR_MAX 6'h3e
`define CLK_MHZ 125
`define WAKE_BLANK_US 200
// longest time rounds down: 200 us at 125 MHz
`define WAKE_BLANK_CYC ((`WAKE_BLANK_US * `CLK_MHZ))
`define RESET_CTRL 1'b0

`endif

/* File: rtl/protector_fault_alert_logic.v */
/*
 * secondary-protector status logic for one stacked cell-monitor device:
 * overtemperature filter/latch, fault and alert latches, chain pins,
 * force self-test and cell-balance outputs.
 * assumes the analog comparators hand over per-code trip and release
 * levels already synchronous-safe via the two-flop input stage below, and
 * that serial-bus decoding supplies one-cycle write strobes on i_clk.
 */
// ----------------------------------------------------------------
// Overview of operation
// - overtemp flag sets after threshold held past delay
// - alert flags ORed to status bit and pin
// - nonzero delay latches; zero delay follows condition
// - code 0 disabled, codes 1-11 trip points
// - comparator trips at set, releases at clear ratio
// - two thresholds, one shared filter delay
// - thermistor power bits reset 0, ground returns
// - overtemp detection blanked about 200 us after sleep
// - north fault/alert input drives south output
// - base device drives host-side fault from north
// - fault sources each set bit and status fault
// - alert sources each set own alert bit
// - flags clear only by host write of one, except zero-delay overtemp flags
// - force bits written directly, cleared by zero
// - force in top device propagates down chain
// - balance outputs copy the six control bits
// - clearing a flag restarts its filter timer
// - balance timer expiry forces outputs off
// ----------------------------------------------------------------
`include "protector_defines.vh"
`timescale 1ns/1ps
`default_nettype none

module protector_fault_alert_logic #(
   parameter DELAY_W = 24,
   parameter WAKE_BLANK_CYCLES = `WAKE_BLANK_CYC
) (
   // clock and reset
   input wire i_clk,
   input wire i_nrst,
   // temperature comparator levels per input: bit k = above set/clear ratio of code k+1
   input wire [10:0] i_temp_input_one_above_set,
   input wire [10:0] i_temp_input_one_above_clear,
   input wire [10:0] i_temp_input_two_above_set,
   input wire [10:0] i_temp_input_two_above_clear,
   // configuration
   input wire [3:0] i_overtemp_threshold_one_cfg,
   input wire [3:0] i_overtemp_threshold_two_cfg,
   input wire [DELAY_W-1:0] i_overtemp_delay_cfg,
   input wire [5:0] i_device_address,
   // raw event sources (from pins or other clock-unrelated logic)
   input wire i_ecc_double_err,
   input wire i_por_event,
   input wire i_crc_err,
   input wire i_cell_undervoltage_flag,
   input wire i_cell_overvoltage_flag,
   input wire i_parity_err,
   input wire i_ecc_corrected_flag,
   input wire i_thermal_shutdown_flag,
   input wire i_sleep_exit,
   // chain pins and strap
   input wire i_fault_north,
   input wire i_alert_north,
   input wire i_host_select,
   // host writes (one-cycle strobes); balance safety timer expiry level
   input wire i_fault_wr,
   input wire [`FLT_WIDTH-1:0] i_fault_wdata,
   input wire i_alert_wr,
   input wire [`ALR_WIDTH-1:0] i_alert_wdata,
   input wire i_therm_pwr_wr,
   input wire [1:0] i_therm_pwr_wdata,
   input wire i_balance_wr,
   input wire [5:0] i_balance_wdata,
   input wire i_balance_safety_timer_expired,
   // status
   output reg [`FLT_WIDTH-1:0] o_fault_status,
   output reg [`ALR_WIDTH-1:0] o_alert_status,
   output reg o_dev_fault,
   output reg o_dev_alert,
   output reg o_overtemp_one,
   output reg o_overtemp_two,
   // pins
   output reg o_fault_south,
   output reg o_alert_south,
   output reg o_fault_host,
   output reg o_alert_host,
   output reg [1:0] o_therm_return_gnd,
   output reg [5:0] o_balance_outputs
);

   // ----------------------------------------------------------------
   // reset release and input synchronisers
   // ----------------------------------------------------------------
   localparam NSYNC = 56;
   reg [1:0] rst_q;
   wire rst_n = rst_q[1];
   // release through two flops so every register leaves reset together
   always @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst)
         rst_q <= 2'b00;
      else
         rst_q <= {rst_q[0], 1'b1};
   end

   wire [NSYNC-1:0] raw_in = {i_temp_input_one_above_set, i_temp_input_one_above_clear,
      i_temp_input_two_above_set, i_temp_input_two_above_clear, i_ecc_double_err,
      i_por_event, i_crc_err, i_cell_undervoltage_flag, i_cell_overvoltage_flag,
      i_parity_err, i_ecc_corrected_flag, i_thermal_shutdown_flag, i_sleep_exit,
      i_fault_north, i_alert_north, i_host_select};
   reg [NSYNC-1:0] sync1_q;
   reg [NSYNC-1:0] sync2_q;
   // two flops per pin; only sync2_q is read by logic
   always @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         sync1_q <= {NSYNC{1'b0}};
         sync2_q <= {NSYNC{1'b0}};
      end else begin
         sync1_q <= raw_in;
         sync2_q <= sync1_q;
      end
   end
   wire [10:0] one_set = sync2_q[55:45];
   wire [10:0] one_clr = sync2_q[44:34];
   wire [10:0] two_set = sync2_q[33:23];
   wire [10:0] two_clr = sync2_q[22:12];
   wire s_ecc2 = sync2_q[11];
   wire s_por = sync2_q[10];
   wire s_crc = sync2_q[9];
   wire s_cuv = sync2_q[8];
   wire s_cov = sync2_q[7];
   wire s_par = sync2_q[6];
   wire s_ecc1 = sync2_q[5];
   wire s_tsd = sync2_q[4];
   wire s_sleep = sync2_q[3];
   wire s_fnorth = sync2_q[2];
   wire s_anorth = sync2_q[1];
   wire s_hsel = sync2_q[0];

   // ----------------------------------------------------------------
   // wake blanking after sleep exit
   // ----------------------------------------------------------------
   reg sleep_prev_q;
   reg [15:0] blank_q;
   wire blanking = (blank_q != 16'h0000);
   wire wake_edge = s_sleep && !sleep_prev_q;
   // comparators held off while internal references settle; the wake edge
   // itself is blanked too, since the comparator levels arrive with it
   always @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         sleep_prev_q <= 1'b0;
         blank_q <= 16'h0000;
      end else begin
         sleep_prev_q <= s_sleep;
         if (wake_edge)
            blank_q <= WAKE_BLANK_CYCLES[15:0];
         else if (blanking)
            blank_q <= blank_q - 16'h0001;
      end
   end

   // ----------------------------------------------------------------
   // overtemperature comparators with hysteresis and shared filter delay
   // ----------------------------------------------------------------
   wire [3:0] thr_cfg [0:1];
   wire [10:0] lvl_set [0:1];
   wire [10:0] lvl_clr [0:1];
   assign thr_cfg[0] = i_overtemp_threshold_one_cfg;
   assign thr_cfg[1] = i_overtemp_threshold_two_cfg;
   assign lvl_set[0] = one_set;
   assign lvl_set[1] = two_set;
   assign lvl_clr[0] = one_clr;
   assign lvl_clr[1] = two_clr;
   wire [1:0] ot_flag;
   wire [1:0] ot_clear_wr = {i_alert_wr & i_alert_wdata[`ALR_OT2] & o_alert_status[`ALR_OT2],
      i_alert_wr & i_alert_wdata[`ALR_OT1] & o_alert_status[`ALR_OT1]};
   wire no_delay = (i_overtemp_delay_cfg == {DELAY_W{1'b0}});

   genvar g;
   generate
      for (g = 0; g < 2; g = g + 1) begin : g_ot
         reg hot_q;
         reg lat_q;
         reg [DELAY_W-1:0] cnt_q;
         wire valid = (thr_cfg[g] != `OT_CODE_DISABLED) && (thr_cfg[g] <= `OT_CODE_MAX);
         wire [3:0] idx = thr_cfg[g] - 4'h1;
         wire cmp_set = valid && lvl_set[g][idx];
         wire cmp_clr = valid && lvl_clr[g][idx];
         // trip at set ratio, hold until below clear ratio
         always @(posedge i_clk or negedge rst_n) begin
            if (!rst_n)
               hot_q <= 1'b0;
            else if (blanking || wake_edge || !o_therm_return_gnd[g])
               hot_q <= 1'b0;
            else if (cmp_set)
               hot_q <= 1'b1;
            else if (!cmp_clr)
               hot_q <= 1'b0;
         end
         // filter counter; restarts on drop or host clear
         always @(posedge i_clk or negedge rst_n) begin
            if (!rst_n) begin
               cnt_q <= {DELAY_W{1'b0}};
               lat_q <= 1'b0;
            end else begin
               if (!hot_q || ot_clear_wr[g])
                  cnt_q <= {DELAY_W{1'b0}};
               else if (cnt_q != i_overtemp_delay_cfg)
                  cnt_q <= cnt_q + {{(DELAY_W-1){1'b0}}, 1'b1};
               if (hot_q && !no_delay && cnt_q == i_overtemp_delay_cfg && !ot_clear_wr[g])
                  lat_q <= 1'b1;
               else if (ot_clear_wr[g] || no_delay)
                  lat_q <= 1'b0;
            end
         end
         // zero delay: follow live condition, no latch
         assign ot_flag[g] = no_delay ? hot_q : lat_q;
      end
   endgenerate

   // ----------------------------------------------------------------
   // fault and alert latches
   // ----------------------------------------------------------------
   wire addr_bad = (i_device_address < `ADDR_MIN) || (i_device_address > `ADDR_MAX);
   wire [`FLT_WIDTH-1:0] flt_src;
   wire [`ALR_WIDTH-1:0] alr_src;
   assign flt_src = {s_cov, s_cuv, s_crc, s_por, 1'b0, s_ecc2};
   assign alr_src = {2'b00, wake_edge, s_tsd, 1'b0,
      s_ecc1, s_par, addr_bad};
   reg [`FLT_WIDTH-1:0] flt_d;
   reg [`ALR_WIDTH-1:0] alr_d;
   // set wins over clear except on latched overtemp bits; force bits are plain host-written storage
   always @* begin
      flt_d = o_fault_status & ~({`FLT_WIDTH{i_fault_wr}} & i_fault_wdata);
      flt_d = flt_d | flt_src;
      flt_d[`FLT_FORCE] = i_fault_wr ? i_fault_wdata[`FLT_FORCE]
         : o_fault_status[`FLT_FORCE];
      alr_d = o_alert_status & ~({`ALR_WIDTH{i_alert_wr}} & i_alert_wdata);
      alr_d = alr_d | alr_src;
      alr_d[`ALR_FORCE] = i_alert_wr ? i_alert_wdata[`ALR_FORCE]
         : o_alert_status[`ALR_FORCE];
      alr_d[`ALR_OT1] = ot_flag[0];
      alr_d[`ALR_OT2] = ot_flag[1];
   end
   always @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         o_fault_status <= {`FLT_WIDTH{1'b0}};
         o_alert_status <= {`ALR_WIDTH{1'b0}};
      end else begin
         o_fault_status <= flt_d;
         o_alert_status <= alr_d;
      end
   end

   // ----------------------------------------------------------------
   // aggregation and chain pins
   // ----------------------------------------------------------------
   // host-facing pins only on the base device; south pins always carry the chain
   always @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         o_dev_fault <= 1'b0;
         o_dev_alert <= 1'b0;
         o_overtemp_one <= 1'b0;
         o_overtemp_two <= 1'b0;
         o_fault_south <= 1'b0;
         o_alert_south <= 1'b0;
         o_fault_host <= 1'b0;
         o_alert_host <= 1'b0;
      end else begin
         o_dev_fault <= |o_fault_status;
         o_dev_alert <= |o_alert_status;
         o_overtemp_one <= o_alert_status[`ALR_OT1];
         o_overtemp_two <= o_alert_status[`ALR_OT2];
         o_fault_south <= (|o_fault_status) | s_fnorth;
         o_alert_south <= (|o_alert_status) | s_anorth;
         o_fault_host <= !s_hsel && ((|o_fault_status) | s_fnorth);
         o_alert_host <= !s_hsel && ((|o_alert_status) | s_anorth);
      end
   end

   // ----------------------------------------------------------------
   // thermistor power and cell balance
   // ----------------------------------------------------------------
   reg [5:0] bal_q;
   always @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         o_therm_return_gnd <= {2{`RESET_CTRL}};
         bal_q <= 6'h00;
         o_balance_outputs <= 6'h00;
      end else begin
         if (i_therm_pwr_wr)
            o_therm_return_gnd <= i_therm_pwr_wdata;
         if (i_balance_wr)
            bal_q <= i_balance_wdata;
         // expiry timer lives outside; its level gates every output
         o_balance_outputs <= i_balance_safety_timer_expired ? 6'h00 : bal_q;
      end
   end

endmodule // protector_fault_alert_logic

`default_nettype wire

/* File: sim/protector_fault_alert_logic_monitor.sv */
/* port assertions for the protector status block.
   assumes bind by port name and two-flop input sync in the block. */
`timescale 1ns/1ps
`default_nettype none
module protector_checker (
   // inputs seen by the block
   input wire logic i_clk, i_nrst, i_host_select, i_fault_north, i_alert_north,
   input wire logic i_fault_wr, i_alert_wr, i_therm_pwr_wr, i_balance_wr,
   input wire logic i_balance_safety_timer_expired,
   input wire logic [5:0] i_fault_wdata, i_balance_wdata,
   input wire logic [7:0] i_alert_wdata,
   input wire logic [1:0] i_therm_pwr_wdata,
   // outputs of the block
   input wire logic [5:0] o_fault_status, o_balance_outputs,
   input wire logic [7:0] o_alert_status,
   input wire logic [1:0] o_therm_return_gnd,
   input wire logic o_dev_fault, o_dev_alert, o_overtemp_one, o_overtemp_two,
   input wire logic o_fault_south, o_alert_south, o_fault_host, o_alert_host
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_nrst);
   // shadow of last written control bits
   logic [5:0] bal_q;
   logic [1:0] tp_q;
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         bal_q <= 6'h00;
         tp_q <= 2'h0;
      end else begin
         if (i_balance_wr) bal_q <= i_balance_wdata;
         if (i_therm_pwr_wr) tp_q <= i_therm_pwr_wdata;
      end
   end
   property p_dev_alert; o_dev_alert == |$past(o_alert_status); endproperty
   property p_dev_fault;
      o_dev_fault == |$past(o_fault_status) && (!o_dev_fault || o_fault_south)
         && (!o_dev_alert || o_alert_south);
   endproperty
   property p_ot; {o_overtemp_one, o_overtemp_two} == $past(o_alert_status[7:6]); endproperty
   property p_flt_hold; |($past(o_fault_status) & ~o_fault_status) |-> $past(i_fault_wr);
   endproperty
   property p_alr_hold;
      |($past(o_alert_status[5:0]) & ~o_alert_status[5:0]) |-> $past(i_alert_wr);
   endproperty
   property p_force;
      (i_fault_wr |=> o_fault_status[1] == $past(i_fault_wdata[1])) and
      (i_alert_wr |=> o_alert_status[3] == $past(i_alert_wdata[3]));
   endproperty
   property p_chain;
      (i_fault_north[*7] |-> o_fault_south) and (i_alert_north[*7] |-> o_alert_south);
   endproperty
   property p_host;
      ((i_fault_north && !i_host_select)[*4] |-> o_fault_host) and
      (i_host_select[*4] |-> !o_fault_host && !o_alert_host);
   endproperty
   property p_bal;
      (!i_balance_wr && !i_balance_safety_timer_expired)[*4] |-> o_balance_outputs == bal_q;
   endproperty
   property p_bal_off; i_balance_safety_timer_expired[*4] |-> o_balance_outputs == 6'h00;
   endproperty
   property p_therm; (!i_therm_pwr_wr)[*2] |-> o_therm_return_gnd == tp_q; endproperty
   a_dev_alert: assert property (p_dev_alert) else $error("dev alert wrong");
   a_dev_fault: assert property (p_dev_fault) else $error("dev fault wrong");
   a_ot: assert property (p_ot) else $error("ot flag wrong");
   a_flt_hold: assert property (p_flt_hold) else $error("fault dropped");
   a_alr_hold: assert property (p_alr_hold) else $error("alert dropped");
   a_force: assert property (p_force) else $error("force bit wrong");
   a_chain: assert property (p_chain) else $error("chain pin wrong");
   a_host: assert property (p_host) else $error("host pin wrong");
   a_bal: assert property (p_bal) else $error("balance wrong");
   a_bal_off: assert property (p_bal_off) else $error("balance on");
   a_therm: assert property (p_therm) else $error("therm wrong");
   c_ot: cover property ($rose(o_overtemp_one));
   c_host: cover property ($rose(o_fault_host));
   c_force: cover property (i_alert_wr && i_alert_wdata[3]);
endmodule // protector_checker
bind protector_fault_alert_logic protector_checker u_chk (.*);
`default_nettype wire

/* File: sim/upper_neighbour_model.sv */
/* next higher device in the stack, seen only by its south lines.
   assumes the bench drives presence and force requests. */
`timescale 1ns/1ps
`default_nettype none
module upper_neighbour_model (
   // requests from the bench
   input wire logic i_clk,
   input wire logic i_present,
   input wire logic i_fault_force,
   input wire logic i_alert_force,
   // south lines of the higher device
   output logic o_fault_south,
   output logic o_alert_south
);
   // registered like a pin; no device above reads idle
   always_ff @(posedge i_clk) begin
      o_fault_south <= i_present & i_fault_force;
      o_alert_south <= i_present & i_alert_force;
   end
endmodule // upper_neighbour_model
`default_nettype wire

/* File: sim/tb_protector_fault_alert_logic.sv */
/* self-checking bench for the protector status block.
   assumes the checker bind and the neighbour model are compiled first. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin checks_done++; if ((s) !== (e)) begin bad_count++; \
   $display("FAIL %s expected %0h seen %0h", n, e, s); end end
module tb_protector_fault_alert_logic;
   logic i_clk = 0, i_nrst = 0, i_host_select = 0, i_sleep_exit = 0;
   logic i_fault_wr = 0, i_alert_wr = 0, i_therm_pwr_wr = 0, i_balance_wr = 0;
   logic i_balance_safety_timer_expired = 0, up_present = 0, up_ff = 0, up_af = 0;
   logic [10:0] i_temp_input_one_above_set = '0, i_temp_input_one_above_clear = '0;
   logic [10:0] i_temp_input_two_above_set = '0, i_temp_input_two_above_clear = '0;
   logic [3:0] i_overtemp_threshold_one_cfg = '0, i_overtemp_threshold_two_cfg = '0;
   logic [23:0] i_overtemp_delay_cfg = '0;
   logic [5:0] i_fault_wdata = '0, i_balance_wdata = '0, o_fault_status, o_balance_outputs;
   logic [7:0] i_alert_wdata = '0, o_alert_status, r = 8'h2a;
   logic [1:0] i_therm_pwr_wdata = '0, o_therm_return_gnd;
   logic [11:0] src = '0;
   logic o_dev_fault, o_dev_alert, o_overtemp_one, o_overtemp_two;
   logic o_fault_south, o_alert_south, o_fault_host, o_alert_host;
   wire i_fault_north, i_alert_north;
   int bad_count = 0, checks_done = 0, ef = 0, ea = 0;
   int srcs[9] = '{0, 2, 3, 4, 5, 6, 7, 8, 10};
   // event sources share one vector so a loop can walk them
   wire i_ecc_double_err = src[0], i_por_event = src[2], i_crc_err = src[3];
   wire i_cell_undervoltage_flag = src[4], i_cell_overvoltage_flag = src[5];
   wire i_parity_err = src[7], i_ecc_corrected_flag = src[8];
   wire i_thermal_shutdown_flag = src[10];
   wire [5:0] i_device_address = src[6] ? 6'h00 : 6'h3e;
   always #4 i_clk = ~i_clk;
   protector_fault_alert_logic #(.WAKE_BLANK_CYCLES(20)) u_dut (.*);
   upper_neighbour_model u_up (.i_clk(i_clk), .i_present(up_present), .i_fault_force(up_ff),
      .i_alert_force(up_af), .o_fault_south(i_fault_north), .o_alert_south(i_alert_north));
   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction
   task automatic cyc(input int n);
      repeat (n) @(posedge i_clk);
   endtask
   task automatic end_sim;
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // host status write; pins need two edges to follow
   task automatic wr(input bit a, input logic [7:0] d);
      if (a) begin i_alert_wdata <= d; i_alert_wr <= 1; end
      else begin i_fault_wdata <= d[5:0]; i_fault_wr <= 1; end
      cyc(1);
      i_alert_wr <= 0;
      i_fault_wr <= 0;
      cyc(6);
   endtask
   // comparator levels: inputs above codes 1..a and 1..b
   task automatic lvl(input int a, input int b);
      i_temp_input_one_above_set <= 11'h7ff >> (11 - a);
      i_temp_input_one_above_clear <= 11'h7ff >> (11 - a);
      i_temp_input_two_above_set <= 11'h7ff >> (11 - b);
      i_temp_input_two_above_clear <= 11'h7ff >> (11 - b);
   endtask
   task automatic chk_st;
      logic nf, na;
      nf = up_present & up_ff;
      na = up_present & up_af;
      `CHK("fault_status", ef[5:0], o_fault_status)
      `CHK("alert_status", ea[7:0], o_alert_status)
      `CHK("dev_bits", {|ef, |ea}, {o_dev_fault, o_dev_alert})
      `CHK("south", {|ef | nf, |ea | na}, {o_fault_south, o_alert_south})
      `CHK("host", {(|ef | nf) & !i_host_select, (|ea | na) & !i_host_select},
         {o_fault_host, o_alert_host})
      `CHK("ot", {ea[7], ea[6]}, {o_overtemp_one, o_overtemp_two})
   endtask
   // ---------------------------------------------
   // main sequence
   // ---------------------------------------------
   initial begin
      cyc(16);
      i_nrst <= 1;
      cyc(4);
      `CHK("therm", 2'h0, o_therm_return_gnd)
      chk_st();
      // wake with a hot input, no filter: blanking hides it at first
      i_therm_pwr_wdata <= 2'h3;
      i_therm_pwr_wr <= 1;
      cyc(1);
      i_therm_pwr_wr <= 0;
      i_overtemp_threshold_one_cfg <= 4'h1;
      lvl(11, 0);
      i_sleep_exit <= 1;
      cyc(8);
      ea = 'h20;
      chk_st();
      `CHK("therm", 2'h3, o_therm_return_gnd)
      cyc(30);
      ea = 'ha0;
      chk_st();
      i_temp_input_one_above_set <= '0;
      cyc(6);
      chk_st();
      i_temp_input_one_above_clear <= '0;
      cyc(6);
      ea = 'h20;
      chk_st();
      wr(1, 8'h20);
      ea = 0;
      chk_st();
      $display("test wake done");
      // every code on input one, random level on input two
      for (int c = 0; c < 12; c++) begin
         r = lfsr(r);
         i_overtemp_threshold_one_cfg <= c[3:0];
         i_overtemp_threshold_two_cfg <= c[3:0];
         lvl(c, r % 12);
         cyc(6);
         ea = (c > 0 ? 'h80 : 0) | (c > 0 && r % 12 >= c ? 'h40 : 0);
         chk_st();
         lvl(c > 0 ? c - 1 : 0, 0);
         cyc(6);
         ea = 0;
         chk_st();
      end
      // codes above the table behave as disabled even with hot inputs
      i_overtemp_threshold_one_cfg <= 4'hc;
      i_overtemp_threshold_two_cfg <= 4'hf;
      lvl(11, 11);
      cyc(6);
      chk_st();
      lvl(0, 0);
      cyc(6);
      $display("test codes done");
      // filter far above input settling, so short bursts never trip
      i_overtemp_delay_cfg <= 24'h00_000a;
      i_overtemp_threshold_one_cfg <= 4'h3;
      i_overtemp_threshold_two_cfg <= 4'h0;
      lvl(3, 0);
      cyc(6);
      lvl(0, 0);
      cyc(3);
      lvl(3, 0);
      cyc(8);
      lvl(0, 0);
      cyc(6);
      chk_st();
      lvl(3, 0);
      cyc(30);
      ea = 'h80;
      chk_st();
      wr(1, 8'h80);
      ea = 0;
      chk_st();
      cyc(20);
      ea = 'h80;
      chk_st();
      lvl(0, 0);
      cyc(20);
      chk_st();
      wr(1, 8'h80);
      wr(1, 8'h00);
      ea = 0;
      chk_st();
      $display("test filter done");
      // each source: a clear while active is overridden, then latched
      foreach (srcs[k]) begin
         src[srcs[k]] <= 1;
         cyc(6);
         if (srcs[k] < 6) ef = 1 << srcs[k];
         else ea = 1 << (srcs[k] - 6);
         wr(srcs[k] >= 6, 8'(ef | ea));
         chk_st();
         src[srcs[k]] <= 0;
         cyc(6);
         chk_st();
         wr(srcs[k] >= 6, 8'(ef | ea));
         ef = 0;
         ea = 0;
         chk_st();
      end
      $display("test sources done");
      for (int a = 0; a < 2; a++) begin
         wr(a, a ? 8'h08 : 8'h02);
         ef = a ? 0 : 2;
         ea = a ? 8 : 0;
         chk_st();
         wr(a, a ? 8'hff : 8'h3f);
         chk_st();
         i_host_select <= 1;
         cyc(6);
         chk_st();
         i_host_select <= 0;
         wr(a, 8'h00);
         ef = 0;
         ea = 0;
         chk_st();
      end
      up_present <= 1;
      up_ff <= 1;
      up_af <= 1;
      cyc(6);
      chk_st();
      i_host_select <= 1;
      cyc(6);
      chk_st();
      up_present <= 0;
      i_host_select <= 0;
      cyc(6);
      chk_st();
      $display("test chain done");
      repeat (4) begin
         r = lfsr(r);
         i_balance_wdata <= r[5:0];
         i_balance_wr <= 1;
         cyc(1);
         i_balance_wr <= 0;
         cyc(2);
         `CHK("balance", r[5:0], o_balance_outputs)
         i_balance_safety_timer_expired <= 1;
         cyc(4);
         `CHK("balance_off", 6'h00, o_balance_outputs)
         i_balance_safety_timer_expired <= 0;
         cyc(4);
      end
      $display("test balance done");
      end_sim();
   end
   // hang guard, far beyond the roughly 700 cycles used
   initial begin
      cyc(20000);
      bad_count++;
      end_sim();
   end
endmodule // tb_protector_fault_alert_logic
`default_nettype wire
